// >>> hdl/fspc_ctrl.sv
// Sector erase, byte program and read-out protection controller
`timescale 1ns/1ps
`default_nettype none
`include "fspc_regs.svh"

// Functional notes
// - Whole or sector erase; byte-wise programming
// - Sector erase touches only that sector
// - Tool and circuit modes alter everything
// - Application mode never alters sector zero
// - Sector count follows array size
// - Sectors 0,1 are 4K, top placed
// - Protection blocks reads out and writes
// - Unprotecting first erases whole array automatically
// - Protection follows option byte bit, or the mask strap on mask parts
// - Mask parts fix protection permanently
// - Protection disables low voltage supervisor, except on mask parts
module fspc_ctrl
    import fspc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Configuration straps
    input  wire logic        mask_part,
    input  wire logic        mask_protect,
    input  wire logic [1:0]  array_size,
    input  wire fspc_mode_e  mode,
    input  wire logic        external_read,
    // Request port
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire fspc_req_s   req,
    // Answer port
    output logic             rsp_valid,
    output logic             rsp_refused,
    output logic      [7:0]  rsp_data,
    // Status
    output logic             readout_protect_bit,
    output logic             low_voltage_supervisor_en
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Sector index of an address: 0 at top, 1 below, 2 for the rest
    function automatic logic [1:0] sector_of(input logic [15:0] a);
        if (a[15:12] == 4'(`FSPC_SECT0_BASE >> 12))
            sector_of = 2'h0;
        else if (a[15:12] == 4'(`FSPC_SECT1_BASE >> 12))
            sector_of = 2'h1;
        else
            sector_of = 2'h2;
    endfunction : sector_of

    // Whether a sector exists for the strapped array size
    function automatic logic sector_present(input logic [1:0] s, input logic [1:0] sz);
        if (sz == `FSPC_SIZE_4K)
            sector_present = (s == 2'h0);
        else if (sz == `FSPC_SIZE_8K)
            sector_present = (s != 2'h2);
        else
            sector_present = 1'b1;
    endfunction : sector_present

    // Lowest address of the array for the strapped size
    function automatic logic [15:0] array_floor(input logic [1:0] sz);
        if (sz == `FSPC_SIZE_4K)
            array_floor = `FSPC_SECT0_BASE;
        else if (sz == `FSPC_SIZE_8K)
            array_floor = `FSPC_SECT1_BASE;
        else
            array_floor = 16'h0000;
    endfunction : array_floor

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_CYC = 8'(`FSPC_OP_CYCLES);

    fspc_state_e state, next_state;
    logic [7:0]  opt, next_opt;
    logic [7:0]  wait_cnt, next_wait_cnt;
    logic [15:0] ptr, next_ptr, end_ptr, next_end_ptr;
    logic [7:0]  pend_opt, next_pend_opt;
    logic        next_rsp_valid, next_rsp_refused, rd_pend, next_rd_pend;
    logic        protect;
    fspc_mem_s   acc;
    logic [7:0]  mem_rdata;
    logic [1:0]  req_sect;
    logic        allowed;

    // Protection source: mask option or option byte bit
    assign protect = mask_part ? mask_protect : opt[`FSPC_OPT_RDP_BIT];
    assign readout_protect_bit = protect;
    assign low_voltage_supervisor_en = ~(protect & ~mask_part);
    assign req_ready = (state == FSPC_ST_IDLE);
    assign req_sect = sector_of(req.addr);

    // Legality of a modifying request
    always_comb
    begin
        allowed = 1'b1;
        if (mask_part)
            allowed = 1'b0;
        else if (protect && req.cmd != FSPC_CMD_OPT)
            allowed = 1'b0;
        else if (mode == FSPC_MODE_IAP && req.cmd == FSPC_CMD_OPT)
            allowed = 1'b0;
        else if (mode == FSPC_MODE_IAP && req.cmd != FSPC_CMD_MASS && req_sect == 2'h0)
            allowed = 1'b0;
        else if (mode == FSPC_MODE_IAP && req.cmd == FSPC_CMD_MASS)
            allowed = 1'b0;
        else if (req.cmd != FSPC_CMD_MASS && req.cmd != FSPC_CMD_OPT
                 && !sector_present(req_sect, array_size))
            allowed = 1'b0;
    end

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state       = state;
        next_opt         = opt;
        next_wait_cnt    = wait_cnt;
        next_ptr         = ptr;
        next_end_ptr     = end_ptr;
        next_pend_opt    = pend_opt;
        next_rsp_valid   = 1'b0;
        next_rsp_refused = 1'b0;
        next_rd_pend     = 1'b0;
        acc.we           = 1'b0;
        acc.addr         = ptr;
        acc.wdata        = `FSPC_ERASED_BYTE;
        case (state)
            FSPC_ST_IDLE:
            begin
                acc.addr = req.addr;
                if (rd_pend)
                    next_rsp_valid = 1'b1;
                if (req_valid && req.cmd == FSPC_CMD_READ)
                begin
                    // Outside reads see nothing while protected
                    if (protect && external_read)
                    begin
                        next_rsp_valid   = 1'b1;
                        next_rsp_refused = 1'b1;
                    end
                    else
                        next_rd_pend = 1'b1;
                end
                else if (req_valid && !allowed)
                begin
                    next_rsp_valid   = 1'b1;
                    next_rsp_refused = 1'b1;
                end
                else if (req_valid && req.cmd == FSPC_CMD_PROG)
                begin
                    acc.we        = 1'b1;
                    acc.wdata     = req.data;
                    next_wait_cnt = OP_CYC;
                    next_state    = FSPC_ST_BUSY;
                end
                else if (req_valid && req.cmd == FSPC_CMD_SECT)
                begin
                    // Erase bounded to one sector only
                    next_ptr     = (req_sect == 2'h2) ? array_floor(array_size)
                                 : {req.addr[15:12], 12'h000};
                    next_end_ptr = (req_sect == 2'h2) ? (`FSPC_SECT1_BASE - 16'h0001)
                                 : {req.addr[15:12], 12'hFFF};
                    next_state   = FSPC_ST_ERASE;
                end
                else if (req_valid && req.cmd == FSPC_CMD_MASS)
                begin
                    next_ptr     = array_floor(array_size);
                    next_end_ptr = 16'hFFFF;
                    next_state   = FSPC_ST_ERASE;
                end
                else if (req_valid && req.cmd == FSPC_CMD_OPT)
                begin
                    if (protect && !req.data[`FSPC_OPT_RDP_BIT])
                    begin
                        // Clear array before protection drops
                        next_pend_opt = req.data;
                        next_ptr      = array_floor(array_size);
                        next_end_ptr  = 16'hFFFF;
                        next_state    = FSPC_ST_AUTO;
                    end
                    else
                    begin
                        next_opt      = req.data;
                        next_wait_cnt = OP_CYC;
                        next_state    = FSPC_ST_BUSY;
                    end
                end
            end
            FSPC_ST_ERASE, FSPC_ST_AUTO:
            begin
                acc.we = 1'b1;
                next_ptr = ptr + 16'h0001;
                if (ptr == end_ptr)
                begin
                    if (state == FSPC_ST_AUTO)
                        next_opt = pend_opt;
                    next_wait_cnt = OP_CYC;
                    next_state    = FSPC_ST_BUSY;
                end
            end
            FSPC_ST_BUSY:
            begin
                next_wait_cnt = wait_cnt - 8'h01;
                if (wait_cnt == 8'h01)
                begin
                    next_rsp_valid = 1'b1;
                    next_state     = FSPC_ST_IDLE;
                end
            end
            default:
                next_state = FSPC_ST_IDLE;
        endcase
    end

    // Registered sequencer state; option byte starts erased (protected)
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state       <= FSPC_ST_IDLE;
            opt         <= `FSPC_OPT_RESET;
            wait_cnt    <= 8'h00;
            ptr         <= 16'h0000;
            end_ptr     <= 16'h0000;
            pend_opt    <= 8'h00;
            rsp_valid   <= 1'b0;
            rsp_refused <= 1'b0;
            rd_pend     <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            opt         <= next_opt;
            wait_cnt    <= next_wait_cnt;
            ptr         <= next_ptr;
            end_ptr     <= next_end_ptr;
            pend_opt    <= next_pend_opt;
            rsp_valid   <= next_rsp_valid;
            rsp_refused <= next_rsp_refused;
            rd_pend     <= next_rd_pend;
        end
    end

    // Read data copied to a flop so the answer stays stable
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rsp_data <= 8'h00;
        else if (rd_pend)
            rsp_data <= mem_rdata;
    end

    fspc_mem u_mem
    (
        .ref_clk (ref_clk),
        .acc     (acc),
        .rdata   (mem_rdata)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    iap_sect0_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (mode == FSPC_MODE_IAP && acc.we) |-> (acc.addr[15:12] != 4'hF || state == FSPC_ST_AUTO))
        else $error("sector zero altered in application mode");
    iap_refuse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (req_valid && req_ready && mode == FSPC_MODE_IAP && req.cmd == FSPC_CMD_PROG
         && req.addr[15:12] == 4'hF) |=> (rsp_valid && rsp_refused))
        else $error("sector zero program not refused");
    prot_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (req_valid && req_ready && protect && req.cmd == FSPC_CMD_PROG) |=> rsp_refused)
        else $error("program accepted while protected");
    prot_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (req_valid && req_ready && protect && external_read && req.cmd == FSPC_CMD_READ)
        |=> (rsp_valid && rsp_refused))
        else $error("outside read not blocked");
    lvs_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!mask_part && readout_protect_bit) |-> !low_voltage_supervisor_en)
        else $error("supervisor active while protected");
    unprot_erase_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state == FSPC_ST_AUTO) |-> readout_protect_bit)
        else $error("protection dropped before erase ended");
    mask_fixed_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (mask_part && $stable(mask_part) && $stable(mask_protect)) |-> $stable(readout_protect_bit))
        else $error("mask protection changed");
    sect_bound_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state == FSPC_ST_ERASE && acc.we) |-> (ptr <= end_ptr))
        else $error("erase ran past its sector");
    prog_done_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state == FSPC_ST_IDLE && req_valid && allowed && req.cmd == FSPC_CMD_PROG)
        |-> ##11 (rsp_valid && !rsp_refused))
        else $error("byte program did not finish in time");

    prog_c:   cover property (@(posedge ref_clk) state == FSPC_ST_BUSY && wait_cnt == 8'h01);
    erase_c:  cover property (@(posedge ref_clk) state == FSPC_ST_ERASE && ptr == end_ptr);
    auto_c:   cover property (@(posedge ref_clk) state == FSPC_ST_AUTO && ptr == end_ptr);
    refuse_c: cover property (@(posedge ref_clk) rsp_valid && rsp_refused);

endmodule : fspc_ctrl

`default_nettype wire

// >>> include/fspc_regs.svh
// Constants for the flash sector protection controller
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH

// ------------------------------------------------------------------
// Array geometry
// ------------------------------------------------------------------
`define FSPC_ADDR_W      16
`define FSPC_SECT_SIZE   16'h1000
`define FSPC_SECT0_BASE  16'hF000
`define FSPC_SECT1_BASE  16'hE000
`define FSPC_SIZE_4K     2'h0
`define FSPC_SIZE_8K     2'h1
`define FSPC_ERASED_BYTE 8'hFF
`define FSPC_OPT_RESET   8'hFF
`define FSPC_OPT_RDP_BIT 0

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define FSPC_OP_TIME_NS  200
`define FSPC_CLK_NS      20
`define FSPC_OP_CYCLES   ((`FSPC_OP_TIME_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS)

`endif

// >>> include/fspc_pkg.sv
// Types for the flash sector protection controller
package fspc_pkg;

    // ------------------------------------------------------------------
    // Modes, commands, states
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        FSPC_MODE_TOOL = 2'h0,
        FSPC_MODE_ICP  = 2'h1,
        FSPC_MODE_IAP  = 2'h2
    } fspc_mode_e;

    typedef enum logic [2:0]
    {
        FSPC_CMD_PROG   = 3'h0,
        FSPC_CMD_SECT   = 3'h1,
        FSPC_CMD_MASS   = 3'h2,
        FSPC_CMD_OPT    = 3'h3,
        FSPC_CMD_READ   = 3'h4
    } fspc_cmd_e;

    typedef enum logic [2:0]
    {
        FSPC_ST_IDLE  = 3'b000,
        FSPC_ST_BUSY  = 3'b001,
        FSPC_ST_ERASE = 3'b011,
        FSPC_ST_WAIT  = 3'b010,
        FSPC_ST_AUTO  = 3'b110
    } fspc_state_e;

    typedef struct packed
    {
        fspc_cmd_e   cmd;
        logic [15:0] addr;
        logic [7:0]  data;
    } fspc_req_s;

    typedef struct packed
    {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fspc_mem_s;

endpackage : fspc_pkg

// >>> hdl/fspc_mem.sv
// Byte-wide array storage with registered read data
`timescale 1ns/1ps
`default_nettype none

module fspc_mem
    import fspc_pkg::*;
(
    // Clock
    input  wire logic        ref_clk,
    // Access
    input  wire fspc_mem_s   acc,
    output logic      [7:0]  rdata
);

    logic [7:0] array [0:65535];

    // Storage has no reset, as a real array would not
    always_ff @(posedge ref_clk)
    begin
        if (acc.we)
        begin
            array[acc.addr] <= acc.wdata;
        end
        rdata <= array[acc.addr];
    end

endmodule : fspc_mem

`default_nettype wire

// >>> bench/fspc_tool_model.sv
// Programming-side request model for the flash controller
`timescale 1ns/1ps
`default_nettype none

module fspc_tool_model
    import fspc_pkg::*;
(
    // Clock
    input  wire logic        ref_clk,
    // Request side
    output logic             req_valid,
    input  wire logic        req_ready,
    output fspc_req_s        req,
    // Answer side
    input  wire logic        rsp_valid,
    input  wire logic        rsp_refused,
    input  wire logic [7:0]  rsp_data
);
    // ------------------------------------------------------------------
    // Request driver
    // ------------------------------------------------------------------
    initial
    begin
        req_valid = 1'b0;
        req       = '0;
    end

    // Hold the request until taken; fields are scrambled once released
    task automatic xfer(input fspc_cmd_e c, input logic [15:0] a, input logic [7:0] d,
                        output logic refd, output logic [7:0] rd, output logic ok);
        logic rdy;
        int   n;
        ok = 1'b0;
        refd = 1'b0;
        rd = 8'h00;
        @(posedge ref_clk);
        #1;
        req_valid = 1'b1;
        req = '{cmd: c, addr: a, data: d};
        for (n = 0; n < 50; n++)
        begin
            @(negedge ref_clk);
            rdy = req_ready;
            @(posedge ref_clk);
            if (rdy === 1'b1)
                break;
        end
        #1;
        req_valid = 1'b0;
        req = ~req;
        // Long erases need a generous bound
        for (n = 0; n < 20000; n++)
        begin
            @(negedge ref_clk);
            if (rsp_valid === 1'b1)
            begin
                refd = rsp_refused;
                rd = rsp_data;
                ok = 1'b1;
                break;
            end
        end
        // Return just after a rising edge so callers drive straps in step
        @(posedge ref_clk);
    endtask : xfer
endmodule : fspc_tool_model

`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench for the flash sector protection controller
`timescale 1ns/1ps
`default_nettype none

module tb
    import fspc_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        mask_part = 1'b0;
    logic        mask_protect = 1'b0;
    logic [1:0]  array_size = 2'h1;
    fspc_mode_e  mode = FSPC_MODE_TOOL;
    logic        external_read = 1'b0;
    logic        req_valid;
    logic        req_ready;
    fspc_req_s   req;
    logic        rsp_valid;
    logic        rsp_refused;
    logic [7:0]  rsp_data;
    logic        prot;
    logic        lvs_en;
    int          err_count = 0;
    int          tests_run = 0;

    always #10 ref_clk = ~ref_clk;

    fspc_ctrl fspc_ctrl_i (.ref_clk(ref_clk), .resetn(resetn), .mask_part(mask_part),
        .mask_protect(mask_protect), .array_size(array_size), .mode(mode),
        .external_read(external_read), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp_refused(rsp_refused), .rsp_data(rsp_data),
        .readout_protect_bit(prot), .low_voltage_supervisor_en(lvs_en));

    fspc_tool_model fspc_tool_model_i (.ref_clk(ref_clk), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp_refused(rsp_refused), .rsp_data(rsp_data));

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    // Byte-wide compare; flags are zero-extended
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One request; answer must arrive and carry the expected refusal
    task automatic op(input fspc_cmd_e c, input logic [15:0] a, input logic [7:0] d,
                      input logic exp_ref);
        logic       refd;
        logic [7:0] rd;
        logic       ok;
        fspc_tool_model_i.xfer(c, a, d, refd, rd, ok);
        chk({7'h0, ok}, 8'h01);
        chk({7'h0, refd}, {7'h0, exp_ref});
    endtask : op

    // Accepted read with expected byte
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic       refd;
        logic [7:0] rd;
        logic       ok;
        fspc_tool_model_i.xfer(FSPC_CMD_READ, a, 8'h00, refd, rd, ok);
        chk({6'h0, ok, refd}, 8'h02);
        chk(rd, exp);
    endtask : rd_chk

    task automatic flags(input logic p, input logic l);
        chk({6'h0, prot, lvs_en}, {6'h0, p, l});
    endtask : flags

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Out of reset the part is protected: writes and outside reads refused
    task automatic t_reset_protected();
        flags(1'b1, 1'b0);
        op(FSPC_CMD_PROG, 16'hF000, 8'h5A, 1'b1);
        op(FSPC_CMD_MASS, 16'h0000, 8'h00, 1'b1);
        #1 external_read = 1'b1;
        op(FSPC_CMD_READ, 16'hF000, 8'h00, 1'b1);
        #1 external_read = 1'b0;
    endtask : t_reset_protected

    // Clearing protection wipes the whole array before anything else
    task automatic t_unprotect();
        op(FSPC_CMD_OPT, 16'h0000, 8'hFE, 1'b0);
        flags(1'b0, 1'b1);
        rd_chk(16'hF000, 8'hFF);
        rd_chk(16'hEFFF, 8'hFF);
    endtask : t_unprotect

    // Byte programs in both top sectors, tool then circuit mode
    task automatic t_program();
        op(FSPC_CMD_PROG, 16'hF000, 8'hA5, 1'b0);
        op(FSPC_CMD_PROG, 16'hFFFF, 8'h11, 1'b0);
        #1 mode = FSPC_MODE_ICP;
        op(FSPC_CMD_PROG, 16'hE000, 8'h3C, 1'b0);
        op(FSPC_CMD_PROG, 16'hEFFF, 8'h77, 1'b0);
        rd_chk(16'hF000, 8'hA5);
        rd_chk(16'hFFFF, 8'h11);
        rd_chk(16'hE000, 8'h3C);
    endtask : t_program

    // Sector erase touches only its own sector
    task automatic t_sector_erase();
        op(FSPC_CMD_SECT, 16'hE123, 8'h00, 1'b0);
        rd_chk(16'hE000, 8'hFF);
        rd_chk(16'hEFFF, 8'hFF);
        rd_chk(16'hF000, 8'hA5);
    endtask : t_sector_erase

    // Application mode: sector zero and whole erase are refused
    task automatic t_iap();
        #1 mode = FSPC_MODE_IAP;
        op(FSPC_CMD_PROG, 16'hF001, 8'h00, 1'b1);
        op(FSPC_CMD_SECT, 16'hF000, 8'h00, 1'b1);
        op(FSPC_CMD_MASS, 16'h0000, 8'h00, 1'b1);
        op(FSPC_CMD_PROG, 16'hE001, 8'hC3, 1'b0);
        rd_chk(16'hF000, 8'hA5);
        rd_chk(16'hF001, 8'hFF);
        rd_chk(16'hE001, 8'hC3);
        #1 mode = FSPC_MODE_TOOL;
    endtask : t_iap

    // Absent sectors refused for the 4K and 8K array sizes; the full size accepts them
    task automatic t_sizes();
        op(FSPC_CMD_PROG, 16'h1000, 8'h00, 1'b1);
        #1 array_size = 2'h0;
        op(FSPC_CMD_PROG, 16'hE002, 8'h00, 1'b1);
        #1 array_size = 2'h2;
        op(FSPC_CMD_PROG, 16'h1000, 8'h99, 1'b0);
        rd_chk(16'h1000, 8'h99);
        #1 array_size = 2'h1;
    endtask : t_sizes

    // Whole erase, then protect again: supervisor off, writes refused
    task automatic t_mass_protect();
        op(FSPC_CMD_MASS, 16'h0000, 8'h00, 1'b0);
        rd_chk(16'hF000, 8'hFF);
        rd_chk(16'hE001, 8'hFF);
        op(FSPC_CMD_OPT, 16'h0000, 8'hFF, 1'b0);
        flags(1'b1, 1'b0);
        op(FSPC_CMD_PROG, 16'hE000, 8'h00, 1'b1);
    endtask : t_mass_protect

    // Mask parts follow the strap and never accept a change
    task automatic t_mask();
        #1 mask_part = 1'b1;
        mask_protect = 1'b0;
        @(posedge ref_clk);
        #1 chk({7'h0, prot}, 8'h00);
        op(FSPC_CMD_OPT, 16'h0000, 8'hFF, 1'b1);
        op(FSPC_CMD_PROG, 16'hE000, 8'h00, 1'b1);
        #1 mask_protect = 1'b1;
        @(posedge ref_clk);
        #1 chk({7'h0, prot}, 8'h01);
        flags(1'b1, 1'b1);
        op(FSPC_CMD_OPT, 16'h0000, 8'hFE, 1'b1);
    endtask : t_mask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge ref_clk);
        #1 resetn = 1'b1;
        t_reset_protected();
        t_unprotect();
        t_program();
        t_sector_erase();
        t_iap();
        t_sizes();
        t_mass_protect();
        t_mask();
        stop_test();
    end

    // Roughly three times the expected run of about 20k cycles
    initial
    begin
        #(60000 * 20);
        err_count++;
        stop_test();
    end
endmodule : tb

`default_nettype wire
